// [fpc_pcs_top.v]
// physical coding sublayer of a 10/100 transceiver: 4b5b, nrzi, manchester, crs/col
`include "fpc_regs.vh"

module fpc_pcs_top #(
    parameter LINE_BIT_CYC = `FPC_LINE_BIT_CYC
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       reset,
    // configuration
    input  wire       speed_100,
    input  wire       full_duplex,
    input  wire       pwr_save_en,
    input  wire       pwr_down,
    // mac transmit side
    input  wire       tx_en,
    input  wire       tx_er,
    input  wire [3:0] txd,
    output reg        tx_nib_stb_ff,
    // mac receive side
    output reg  [3:0] rxd_ff,
    output reg        rx_nib_stb_ff,
    output reg        rx_dv_ff,
    output reg        rx_er_ff,
    output wire       crs,
    output wire       col,
    // line transmit side
    output reg        tx_line_data_ff,
    output reg        tx_line_en_ff,
    // line receive side, from another clock domain
    input  wire       rx_line_clk,
    input  wire       rx_line_data,
    input  wire       rx_line_sq,
    input  wire       media_sig,
    // power status
    output reg        pwr_reduced_ff,
    output wire       flp_en
);
    // ------------------------------------------------------------
    // transmit states, one-hot
    // ------------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_J    = 6'h02;
    localparam [5:0] ST_K    = 6'h04;
    localparam [5:0] ST_DATA = 6'h08;
    localparam [5:0] ST_T    = 6'h10;
    localparam [5:0] ST_R    = 6'h20;
    localparam integer DIV_LAST_I = LINE_BIT_CYC - 1;
    // the divider is 16 bits wide, so the count is cut to fit on purpose
    localparam [15:0] DIV_LAST = DIV_LAST_I[15:0];

    // ------------------------------------------------------------
    // synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------
    reg  [3:0] sync1_ff;
    reg  [3:0] sync2_ff;
    reg        lclk_d_ff;
    wire       lclk_s;
    wire       ldat_s;
    wire       sq_s;
    wire       media_s;

    // first stage feeds only the second stage
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sync1_ff  <= 4'h0;
            sync2_ff  <= 4'h0;
            lclk_d_ff <= 1'b0;
        end else begin
            sync1_ff  <= {media_sig, rx_line_sq, rx_line_data, rx_line_clk};
            sync2_ff  <= sync1_ff;
            lclk_d_ff <= sync2_ff[0];
        end
    end
    assign lclk_s  = sync2_ff[0];
    assign ldat_s  = sync2_ff[1];
    assign sq_s    = sync2_ff[2];
    assign media_s = sync2_ff[3];

    // ------------------------------------------------------------
    // power reduced and power down
    // ------------------------------------------------------------
    wire path_off;

    // media presence wins, so a wake-up is never lost to the entry term
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pwr_reduced_ff <= 1'b0;
        end else if (media_s) begin
            pwr_reduced_ff <= 1'b0;
        end else if (pwr_save_en) begin
            pwr_reduced_ff <= 1'b1;
        end
    end
    // link pulses keep running while reduced, but not in power down
    assign flp_en   = pwr_reduced_ff & ~pwr_down;
    assign path_off = pwr_down | pwr_reduced_ff;

    // ------------------------------------------------------------
    // transmit bit timing
    // ------------------------------------------------------------
    reg  [15:0] div_ff;
    wire        tick;

    // one tick per line bit at 100 Mb/s, per half bit at 10 Mb/s
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_ff <= 16'h0000;
        end else if (div_ff >= DIV_LAST) begin
            div_ff <= 16'h0000;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end
    assign tick = (div_ff >= DIV_LAST);

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    reg  [5:0] tx_st_ff;
    reg  [5:0] nxt_tx_st;
    reg  [4:0] nxt_sym;
    reg        nxt_take;
    reg  [4:0] tx_sh_ff;
    reg  [3:0] tx_nib_ff;
    reg  [2:0] tx_cnt_ff;
    wire [4:0] enc_sym;
    wire       scr_out;
    wire       scr_vld;
    wire       tx_act;
    wire       man_bit;

    fpc_4b5b u_enc (
        .enc_nib  (txd),
        .enc_sym  (enc_sym),
        .dec_sym  (5'h00),
        .dec_nib  (),
        .dec_data (),
        .dec_idle (),
        .dec_t    (),
        .dec_r    (),
        .dec_bad  ()
    );

    assign scr_vld = tick & speed_100 & ~path_off;

    fpc_scrambler #(.DESCR(0)) u_scr (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bit_vld (scr_vld),
        .bit_in  (tx_sh_ff[4]),
        .bit_out (scr_out)
    );

    // choice of the next 100 Mb/s group at each group boundary
    always @* begin
        nxt_tx_st = ST_IDLE;
        nxt_sym   = `FPC_SYM_IDLE;
        nxt_take  = 1'b0;
        case (tx_st_ff)
            ST_IDLE, ST_R: begin
                if (tx_en) begin
                    nxt_tx_st = ST_J;
                    nxt_sym   = `FPC_SYM_J;
                    nxt_take  = 1'b1;
                end
            end
            ST_J: begin
                nxt_tx_st = ST_K;
                nxt_sym   = `FPC_SYM_K;
                nxt_take  = 1'b1;
            end
            ST_K, ST_DATA: begin
                if (tx_en) begin
                    nxt_tx_st = ST_DATA;
                    nxt_sym   = tx_er ? `FPC_SYM_H : enc_sym;
                    nxt_take  = 1'b1;
                end else begin
                    nxt_tx_st = ST_T;
                    nxt_sym   = `FPC_SYM_T;
                end
            end
            ST_T: begin
                nxt_tx_st = ST_R;
                nxt_sym   = `FPC_SYM_R;
            end
            default: begin
                nxt_tx_st = ST_IDLE;
            end
        endcase
    end

    // manchester: first half is the inverse, second half the bit
    assign man_bit = tx_nib_ff[tx_cnt_ff[2:1]] ^ ~tx_cnt_ff[0];

    // serialiser, nrzi coder and 10 Mb/s frame control
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            tx_st_ff        <= ST_IDLE;
            tx_sh_ff        <= `FPC_SYM_IDLE;
            tx_nib_ff       <= 4'h0;
            tx_cnt_ff       <= 3'h0;
            tx_nib_stb_ff   <= 1'b0;
            tx_line_data_ff <= 1'b0;
            tx_line_en_ff   <= 1'b0;
        end else begin
            tx_nib_stb_ff <= 1'b0;
            tx_line_en_ff <= ~path_off;
            if (path_off) begin
                tx_st_ff        <= ST_IDLE;
                tx_sh_ff        <= `FPC_SYM_IDLE;
                tx_cnt_ff       <= 3'h0;
                tx_line_data_ff <= 1'b0;
            end else if (tick && speed_100) begin
                // nrzi: a one on the scrambled stream flips the line
                tx_line_data_ff <= tx_line_data_ff ^ scr_out;
                if (tx_cnt_ff == 3'h4) begin
                    tx_cnt_ff     <= 3'h0;
                    tx_st_ff      <= nxt_tx_st;
                    tx_sh_ff      <= nxt_sym;
                    tx_nib_stb_ff <= nxt_take;
                end else begin
                    tx_cnt_ff <= tx_cnt_ff + 3'h1;
                    tx_sh_ff  <= {tx_sh_ff[3:0], 1'b0};
                end
            end else if (tick) begin
                if (tx_st_ff == ST_DATA) begin
                    tx_line_data_ff <= man_bit;
                    tx_cnt_ff       <= tx_cnt_ff + 3'h1;
                    if (tx_cnt_ff == 3'h7) begin
                        // next nibble follows without a gap
                        tx_st_ff      <= tx_en ? ST_DATA : ST_IDLE;
                        tx_nib_ff     <= txd;
                        tx_nib_stb_ff <= tx_en;
                    end
                end else begin
                    tx_line_data_ff <= 1'b0;
                    tx_cnt_ff       <= 3'h0;
                    tx_st_ff        <= tx_en ? ST_DATA : ST_IDLE;
                    tx_nib_ff       <= txd;
                    tx_nib_stb_ff   <= tx_en;
                end
            end
        end
    end
    assign tx_act = ~tx_st_ff[0] & ~path_off;

    // ------------------------------------------------------------
    // receive: nrzi decode and descramble
    // ------------------------------------------------------------
    reg        rx_prev_ff;
    reg  [9:0] win_ff;
    wire       rx_tick;
    wire       rx_nrz;
    wire       rx_plain;
    wire       dscr_vld;
    wire [9:0] win_new;

    assign rx_tick  = lclk_s & ~lclk_d_ff & ~path_off;
    assign rx_nrz   = ldat_s ^ rx_prev_ff;
    assign dscr_vld = rx_tick & speed_100;

    fpc_scrambler #(.DESCR(1)) u_dscr (
        .ref_clk (ref_clk),
        .reset   (reset),
        .bit_vld (dscr_vld),
        .bit_in  (rx_nrz),
        .bit_out (rx_plain)
    );

    // bit window, newest bit at the bottom
    assign win_new = {win_ff[8:0], rx_plain};

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rx_prev_ff <= 1'b0;
            win_ff     <= 10'h3FF;
        end else if (dscr_vld) begin
            rx_prev_ff <= ldat_s;
            win_ff     <= win_new;
        end
    end

    // ------------------------------------------------------------
    // receive: alignment, lookup and delimiter stripping
    // ------------------------------------------------------------
    reg        aligned_ff;
    reg        in_t_ff;
    reg        pre2_ff;
    reg  [2:0] gcnt_ff;
    reg        half_ff;
    reg        first_ff;
    reg  [1:0] bcnt_ff;
    reg  [3:0] rnib_ff;
    reg        viol_ff;
    wire [3:0] dec_nib;
    wire       dec_data;
    wire       dec_idle;
    wire       dec_t;
    wire       dec_r;
    wire       dec_bad;
    wire       jk_seen;
    wire       rx_act;

    fpc_4b5b u_dec (
        .enc_nib  (4'h0),
        .enc_sym  (),
        .dec_sym  (win_new[4:0]),
        .dec_nib  (dec_nib),
        .dec_data (dec_data),
        .dec_idle (dec_idle),
        .dec_t    (dec_t),
        .dec_r    (dec_r),
        .dec_bad  (dec_bad)
    );

    assign jk_seen = (win_new == {`FPC_SYM_J, `FPC_SYM_K});

    // 100 Mb/s framing and 10 Mb/s manchester regrouping share the outputs
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aligned_ff    <= 1'b0;
            in_t_ff       <= 1'b0;
            pre2_ff       <= 1'b0;
            gcnt_ff       <= 3'h0;
            half_ff       <= 1'b0;
            first_ff      <= 1'b0;
            bcnt_ff       <= 2'h0;
            rnib_ff       <= 4'h0;
            viol_ff       <= 1'b0;
            rxd_ff        <= 4'h0;
            rx_nib_stb_ff <= 1'b0;
            rx_dv_ff      <= 1'b0;
            rx_er_ff      <= 1'b0;
        end else begin
            rx_nib_stb_ff <= 1'b0;
            pre2_ff       <= 1'b0;
            if (pre2_ff) begin
                rxd_ff        <= `FPC_NIB_PRE;
                rx_er_ff      <= 1'b0;
                rx_nib_stb_ff <= 1'b1;
            end
            if (path_off) begin
                aligned_ff <= 1'b0;
                in_t_ff    <= 1'b0;
                rx_dv_ff   <= 1'b0;
                rx_er_ff   <= 1'b0;
                half_ff    <= 1'b0;
                bcnt_ff    <= 2'h0;
            end else if (speed_100) begin
                if (dscr_vld && !aligned_ff && jk_seen) begin
                    aligned_ff    <= 1'b1;
                    gcnt_ff       <= 3'h0;
                    rx_dv_ff      <= 1'b1;
                    rxd_ff        <= `FPC_NIB_PRE;
                    rx_er_ff      <= 1'b0;
                    rx_nib_stb_ff <= 1'b1;
                    pre2_ff       <= 1'b1;
                end else if (dscr_vld && aligned_ff) begin
                    gcnt_ff <= gcnt_ff + 3'h1;
                    if (gcnt_ff == 3'h4) begin
                        gcnt_ff <= 3'h0;
                        if (in_t_ff || dec_idle) begin
                            // frame ends; T and the R group after it never reach the mac
                            aligned_ff    <= 1'b0;
                            in_t_ff       <= 1'b0;
                            rx_dv_ff      <= 1'b0;
                            rx_er_ff      <= 1'b0;
                        end else if (dec_t) begin
                            in_t_ff <= 1'b1;
                        end else begin
                            rxd_ff        <= dec_nib;
                            rx_er_ff      <= dec_bad;
                            rx_nib_stb_ff <= 1'b1;
                        end
                    end
                end
            end else begin
                // 10 Mb/s: squelch marks the frame, halves pair into bits
                aligned_ff <= 1'b0;
                rx_dv_ff   <= sq_s;
                if (!sq_s) begin
                    half_ff  <= 1'b0;
                    bcnt_ff  <= 2'h0;
                    viol_ff  <= 1'b0;
                    rx_er_ff <= 1'b0;
                end else if (rx_tick && !half_ff) begin
                    half_ff  <= 1'b1;
                    first_ff <= ldat_s;
                end else if (rx_tick) begin
                    half_ff <= 1'b0;
                    bcnt_ff <= bcnt_ff + 2'h1;
                    rnib_ff <= {ldat_s, rnib_ff[3:1]};
                    viol_ff <= (bcnt_ff == 2'h0) ? (first_ff == ldat_s)
                                                 : (viol_ff | (first_ff == ldat_s));
                    if (bcnt_ff == 2'h3) begin
                        rxd_ff        <= {ldat_s, rnib_ff[3:1]};
                        rx_er_ff      <= viol_ff | (first_ff == ldat_s);
                        rx_nib_stb_ff <= 1'b1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // carrier sense and collision
    // ------------------------------------------------------------
    assign rx_act = rx_dv_ff;
    assign crs    = full_duplex ? rx_act : (rx_act | tx_act);
    assign col    = full_duplex ? 1'b0 : (rx_act & tx_act);
endmodule

// [fpc_regs.vh]
// constants for the fast ethernet symbol codec: timing, code groups, scrambler taps
`ifndef FPC_REGS_VH
`define FPC_REGS_VH

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define FPC_CLK_NS        20
`define FPC_LINE_BIT_NS   160
// longest time, so rounded down by the integer divide
`define FPC_LINE_BIT_CYC  (`FPC_LINE_BIT_NS / `FPC_CLK_NS)

// ------------------------------------------------------------
// control code groups, transmitted bit 4 first
// ------------------------------------------------------------
`define FPC_SYM_IDLE      5'h1F
`define FPC_SYM_J         5'h18
`define FPC_SYM_K         5'h11
`define FPC_SYM_T         5'h0D
`define FPC_SYM_R         5'h07
`define FPC_SYM_H         5'h04
`define FPC_NIB_PRE       4'h5

// ------------------------------------------------------------
// scrambler polynomial x^11 + x^9 + 1
// ------------------------------------------------------------
`define FPC_SCR_W         11
`define FPC_SCR_TAP_A     10
`define FPC_SCR_TAP_B     8

`endif

// [fpc_scrambler.v]
// self-synchronising bit scrambler, used as scrambler or descrambler
`include "fpc_regs.vh"

module fpc_scrambler #(
    parameter DESCR = 0
) (
    // clock and reset
    input  wire       ref_clk,
    input  wire       reset,
    // bit stream
    input  wire       bit_vld,
    input  wire       bit_in,
    output wire       bit_out
);
    reg  [`FPC_SCR_W-1:0] hist_ff;
    wire                  tap;

    // same xor both ways, so the receive side undoes the transmit side
    assign tap     = hist_ff[`FPC_SCR_TAP_A] ^ hist_ff[`FPC_SCR_TAP_B];
    assign bit_out = bit_in ^ tap;

    // history holds line bits, so the descrambler locks without a seed
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            hist_ff <= {`FPC_SCR_W{1'b0}};
        end else if (bit_vld) begin
            hist_ff <= {hist_ff[`FPC_SCR_W-2:0], (DESCR != 0) ? bit_in : bit_out};
        end
    end
endmodule

// [fpc_4b5b.v]
// 4b5b code table: nibble encoder and group decoder
`include "fpc_regs.vh"

module fpc_4b5b (
    // encoder side
    input  wire [3:0] enc_nib,
    output wire [4:0] enc_sym,
    // decoder side
    input  wire [4:0] dec_sym,
    output reg  [3:0] dec_nib,
    output reg        dec_data,
    output reg        dec_idle,
    output reg        dec_t,
    output reg        dec_r,
    output reg        dec_bad
);
    // data groups for nibbles 0..F
    function [4:0] enc;
        input [3:0] n;
        begin
            case (n)
                4'h0: enc = 5'h1E;
                4'h1: enc = 5'h09;
                4'h2: enc = 5'h14;
                4'h3: enc = 5'h15;
                4'h4: enc = 5'h0A;
                4'h5: enc = 5'h0B;
                4'h6: enc = 5'h0E;
                4'h7: enc = 5'h0F;
                4'h8: enc = 5'h12;
                4'h9: enc = 5'h13;
                4'hA: enc = 5'h16;
                4'hB: enc = 5'h17;
                4'hC: enc = 5'h1A;
                4'hD: enc = 5'h1B;
                4'hE: enc = 5'h1C;
                default: enc = 5'h1D;
            endcase
        end
    endfunction

    assign enc_sym = enc(enc_nib);

    // reverse lookup over the same table, so the two cannot disagree
    integer i;
    always @* begin
        dec_nib  = 4'h0;
        dec_data = 1'b0;
        dec_idle = (dec_sym == `FPC_SYM_IDLE);
        dec_t    = (dec_sym == `FPC_SYM_T);
        dec_r    = (dec_sym == `FPC_SYM_R);
        for (i = 0; i < 16; i = i + 1) begin
            if (enc(i[3:0]) == dec_sym) begin
                dec_nib  = i[3:0];
                dec_data = 1'b1;
            end
        end
        if (dec_sym == `FPC_SYM_J || dec_sym == `FPC_SYM_K) begin
            dec_nib = `FPC_NIB_PRE;
        end
        // error group, invalid groups and stray J/K are flagged bad
        dec_bad = !(dec_data | dec_idle | dec_t | dec_r);
    end
endmodule

// [fpc_pcs_top_asserts.sv]
// concurrent checks on carrier, collision, power and receive outputs of the codec
module fpc_pcs_top_asserts (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       reset,
    // modes and media
    input wire logic       speed_100,
    input wire logic       full_duplex,
    input wire logic       pwr_down,
    input wire logic       media_sig,
    // observed outputs
    input wire logic [3:0] rxd_ff,
    input wire logic       rx_nib_stb_ff,
    input wire logic       rx_dv_ff,
    input wire logic       crs,
    input wire logic       col,
    input wire logic       tx_line_en_ff,
    input wire logic       pwr_reduced_ff,
    input wire logic       flp_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // power down held long enough for the registered outputs to follow
    sequence pd_held;
        pwr_down [*3];
    endsequence
    // the two preamble nibbles that stand in for the start pair
    sequence pre_pair;
        rx_nib_stb_ff && rxd_ff == 4'h5 ##1 rx_nib_stb_ff && rxd_ff == 4'h5;
    endsequence
    a_full_no_col: assert property (full_duplex |-> !col)
        else $error("collision in full duplex");
    a_full_crs_rx: assert property (full_duplex |-> crs == rx_dv_ff)
        else $error("carrier not receive only in full duplex");
    a_col_half_rx: assert property (col |-> rx_dv_ff && crs && !full_duplex)
        else $error("collision without receive in half duplex");
    a_half_crs_rx: assert property (!full_duplex && rx_dv_ff |-> crs)
        else $error("carrier missing while receiving");
    a_flp_reduced: assert property (pwr_reduced_ff && !pwr_down |-> flp_en)
        else $error("link pulses off in reduced state");
    a_pd_quiet: assert property (pd_held |-> !tx_line_en_ff && !rx_nib_stb_ff)
        else $error("activity during power down");
    a_wake_media: assert property (media_sig [*5] |-> !pwr_reduced_ff)
        else $error("reduced state kept with media present");
    a_stb_frame: assert property (rx_nib_stb_ff |-> rx_dv_ff)
        else $error("nibble outside a frame");
    a_pre_pair: assert property (speed_100 && $rose(rx_dv_ff) |-> pre_pair)
        else $error("preamble pair missing at frame start");
endmodule

// [fpc_link_partner.sv]
// remote link partner: scrambled nrzi groups at 100, manchester halves at 10
module fpc_link_partner (
    // line receive pins of the codec
    output logic rx_line_clk,
    output logic rx_line_data,
    output logic rx_line_sq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] scr_ff;
    logic        nrzi_ff;
    // quiet line at time zero; the clock only runs while a task sends bits
    initial begin
        rx_line_clk = 1'b0;
        rx_line_data = 1'b0;
        rx_line_sq = 1'b0;
        scr_ff = 11'h000;
        nrzi_ff = 1'b0;
    end
    // one line bit, settled half a period before the rising edge
    task automatic lbit(input logic b);
        rx_line_data = b;
        #80 rx_line_clk = 1'b1;
        #80 rx_line_clk = 1'b0;
    endtask
    // k copies of a group, bit 4 first, scrambled and then nrzi coded
    task automatic g100(input logic [4:0] g, input int k);
        logic s;
        for (int j = 0; j < k; j++) begin
            for (int i = 4; i >= 0; i--) begin
                s = g[i] ^ scr_ff[10] ^ scr_ff[8];
                scr_ff = {scr_ff[9:0], s};
                nrzi_ff = nrzi_ff ^ s;
                lbit(nrzi_ff);
            end
        end
    endtask
    // one nibble lsb first, each bit as inverted half then true half
    task automatic m10(input logic [3:0] n);
        for (int i = 0; i < 4; i++) begin
            lbit(~n[i]);
            lbit(n[i]);
        end
    endtask
    // squelch edge, with margin so the synchroniser sees it before data
    task automatic sq(input logic b);
        rx_line_sq = b;
        #400 rx_line_data = ~rx_line_data;
    endtask
    // a released line shows the inverse of its last level, never a stale copy
    task automatic rel();
        rx_line_data = ~rx_line_data;
    endtask
endmodule

// [fpc_pcs_top_tb.sv]
// self-checking bench for the fast ethernet symbol codec
module fpc_pcs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk, reset, speed_100, full_duplex, pwr_save_en, pwr_down;
    logic       tx_en, tx_er, media_sig, rx_line_clk, rx_line_data, rx_line_sq;
    logic [3:0] txd;
    wire        tx_nib_stb_ff, rx_nib_stb_ff, rx_dv_ff, rx_er_ff, crs, col;
    wire        tx_line_data_ff, tx_line_en_ff, pwr_reduced_ff, flp_en;
    wire  [3:0] rxd_ff;
    logic [4:0] got_q[$];
    int         fails = 0;
    int         compares = 0;
    int         cyc = 0;
    // rows: group in bits 8:4 beside the nibble it must give in bits 3:0
    logic [8:0] rows [16] = '{9'h1E0, 9'h091, 9'h142, 9'h153, 9'h0A4, 9'h0B5, 9'h0E6,
        9'h0F7, 9'h128, 9'h139, 9'h16A, 9'h17B, 9'h1AC, 9'h1BD, 9'h1CE, 9'h1DF};
    fpc_pcs_top dut (.ref_clk(ref_clk), .reset(reset), .speed_100(speed_100),
        .full_duplex(full_duplex), .pwr_save_en(pwr_save_en), .pwr_down(pwr_down),
        .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_nib_stb_ff(tx_nib_stb_ff),
        .rxd_ff(rxd_ff), .rx_nib_stb_ff(rx_nib_stb_ff), .rx_dv_ff(rx_dv_ff),
        .rx_er_ff(rx_er_ff), .crs(crs), .col(col), .tx_line_data_ff(tx_line_data_ff),
        .tx_line_en_ff(tx_line_en_ff), .rx_line_clk(rx_line_clk),
        .rx_line_data(rx_line_data), .rx_line_sq(rx_line_sq), .media_sig(media_sig),
        .pwr_reduced_ff(pwr_reduced_ff), .flp_en(flp_en));
    fpc_link_partner lp (.rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data),
        .rx_line_sq(rx_line_sq));
    // free running 50 MHz reference
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // capture each delivered nibble with its error flag; cut a hang short
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rx_nib_stb_ff === 1'b1)
            got_q.push_back({rx_er_ff, rxd_ff});
        if (cyc == 20000) begin
            fails = fails + 1;
            wrap_up();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // idles let the descrambler lock before the start pair
    task automatic send100(input int n, input bit bad);
        lp.g100(5'h1F, 12);
        lp.g100(5'h18, 1);
        lp.g100(5'h11, 1);
        for (int i = 0; i < n; i++)
            lp.g100(rows[i][8:4], 1);
        if (bad)
            lp.g100(5'h04, 1);
        if (bad)
            lp.g100(5'h00, 1);
        lp.g100(5'h0D, 1);
        lp.g100(5'h07, 1);
        lp.g100(5'h1F, 2);
        lp.rel();
    endtask
    // compare captured nibbles against the rows, then clear the capture
    task automatic expect_q(input string name, input int pre, input int n, input bit bad);
        repeat (10) @(posedge ref_clk);
        chk(got_q.size(), pre + n + 2 * bad);
        for (int i = 0; i < pre; i++)
            chk(got_q[i], 8'h05);
        for (int i = 0; i < n; i++)
            chk(got_q[pre + i], {4'h0, rows[i][3:0]});
        if (bad)
            chk(got_q[pre + n][4], 8'h01);
        if (bad)
            chk(got_q[pre + n + 1][4], 8'h01);
        got_q.delete();
        $display("test %s done", name);
    endtask
    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // main sequence: table frames, collision, manchester, power states
    initial begin
        reset = 1'b1;
        speed_100 = 1'b1;
        full_duplex = 1'b1;
        pwr_save_en = 1'b0;
        pwr_down = 1'b0;
        tx_en = 1'b0;
        tx_er = 1'b0;
        txd = 4'hA;
        media_sig = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        send100(16, 1);
        expect_q("full duplex table", 2, 16, 1);
        full_duplex <= 1'b0;
        fork
            send100(16, 0);
            begin
                wait (rx_dv_ff === 1'b1);
                @(posedge ref_clk);
                tx_en <= 1'b1;
                for (int k = 0; k < 100 && tx_nib_stb_ff !== 1'b1; k++)
                    @(posedge ref_clk);
                @(posedge ref_clk);
                chk({col, crs}, 8'h03);
            end
        join
        expect_q("half duplex overlap", 2, 16, 0);
        chk({col, crs}, 8'h01);
        tx_en <= 1'b0;
        speed_100 <= 1'b0;
        lp.sq(1'b1);
        for (int i = 0; i < 16; i++)
            lp.m10(rows[i][3:0]);
        lp.sq(1'b0);
        expect_q("manchester", 0, 16, 0);
        chk({tx_line_data_ff, col, crs}, 8'h00);
        speed_100 <= 1'b1;
        pwr_down <= 1'b1;
        repeat (5) @(posedge ref_clk);
        send100(2, 0);
        expect_q("power down", 0, 0, 0);
        chk(tx_line_en_ff, 8'h00);
        pwr_down <= 1'b0;
        media_sig <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(pwr_reduced_ff, 8'h00);
        pwr_save_en <= 1'b1;
        for (int k = 0; k < 500 && pwr_reduced_ff !== 1'b1; k++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        chk({pwr_reduced_ff, flp_en, tx_line_en_ff}, 8'h06);
        media_sig <= 1'b1;
        repeat (8) @(posedge ref_clk);
        chk(pwr_reduced_ff, 8'h00);
        $display("test power reduced done");
        wrap_up();
    end
endmodule
bind fpc_pcs_top fpc_pcs_top_asserts u_chk (.ref_clk(ref_clk), .reset(reset),
    .speed_100(speed_100), .full_duplex(full_duplex), .pwr_down(pwr_down),
    .media_sig(media_sig), .rxd_ff(rxd_ff), .rx_nib_stb_ff(rx_nib_stb_ff),
    .rx_dv_ff(rx_dv_ff), .crs(crs), .col(col), .tx_line_en_ff(tx_line_en_ff),
    .pwr_reduced_ff(pwr_reduced_ff), .flp_en(flp_en));
